// ===== rtl/dcc_core.sv
// Instruction dispatch and in-order retirement control of the core.
`timescale 1ns/1ps
`include "dcc_map.svh"
// Notes on behaviour
// - At most four fetched instructions enter the fetch queue per cycle.
// - Fetch queue holds at most twelve; fetch is refused when it lacks room.
// - Only the three oldest fetch queue slots may dispatch.
// - At most three instructions dispatch per cycle.
// - Per cycle: float queue one, vector queue two, general queue three.
// - Dispatch needs a free retire queue slot, also for queue-less ops.
// - Retire only when all older retired, itself finished, no exception.
// - Retirement is in program order, at most three per cycle.
// - Track branches; a misprediction discards all younger instructions.
// - At most three unresolved branches; a further branch waits.
// - At most sixteen instructions in flight from dispatch to retire.
// - Sixteen rename buffers each for integer, float and vector.
// - Exceptions are precise: only older instructions took effect.
module dcc_core import dcc_pkg::*; #(
	parameter int FQ_DEPTH = `DCC_FQ_DEPTH,
	parameter int RQ_DEPTH = `DCC_RQ_DEPTH,
	parameter int REN_DEPTH = `DCC_REN_DEPTH,
	parameter int BR_MAX = `DCC_BR_MAX
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] fetch_n,
	input wire dcc_op_t [`DCC_FETCH_W-1:0] fetch_ops,
	output logic fetch_rdy,
	input wire logic [1:0] gen_room,
	input wire logic [1:0] vec_room,
	input wire logic flt_room,
	output dcc_disp_t [`DCC_DISP_W-1:0] disp,
	input wire logic [RQ_DEPTH-1:0] fin_mask,
	input wire logic [RQ_DEPTH-1:0] fin_exc,
	input wire dcc_res_t br_res,
	output logic [1:0] ret_cnt,
	output logic flush,
	output logic exc,
	output logic [`DCC_TAG_W-1:0] exc_tag
);
	localparam int TW = `DCC_TAG_W;
	localparam int RW = $clog2(REN_DEPTH + 1);

	initial begin
		if (RQ_DEPTH != (1 << TW) || FQ_DEPTH < `DCC_FETCH_W ||
			FQ_DEPTH > 15 || BR_MAX < 1 || BR_MAX > 3 || REN_DEPTH < 1)
			$error("dcc_core: unsupported parameter values");
	end

	typedef struct packed {
		dcc_op_t [FQ_DEPTH-1:0] fq;
		logic [4:0] fq_cnt;
		logic [RQ_DEPTH-1:0] rq_val;
		logic [RQ_DEPTH-1:0] rq_done;
		logic [RQ_DEPTH-1:0] rq_exc;
		logic [RQ_DEPTH-1:0] rq_br;
		dcc_dest_t [RQ_DEPTH-1:0] rq_dst;
		logic [TW-1:0] head;
		logic [TW-1:0] tail;
		logic [TW:0] rq_cnt;
		logic [2:0][RW-1:0] ren;
		logic [1:0] br_cnt;
		logic fetch_rdy;
		dcc_disp_t [`DCC_DISP_W-1:0] disp;
		logic [1:0] ret_cnt;
		logic flush;
		logic exc;
		logic [TW-1:0] exc_tag;
	} dcc_state_t;

	dcc_state_t s_r;
	dcc_state_t s_nxt;
	logic stop;
	logic ok;
	logic [TW-1:0] idx;
	logic [TW-1:0] age;
	logic [TW-1:0] age_b;
	logic [1:0] ng;
	logic [1:0] nv;
	logic [1:0] nf;
	logic [2:0] nd;
	logic [2:0] fn;
	dcc_op_t op;

	// Returns the rename counts with one buffer of the given kind freed.
	function automatic logic [2:0][RW-1:0] ren_free(
		input logic [2:0][RW-1:0] r, input dcc_dest_t d);
		logic [2:0][RW-1:0] o;
		o = r;
		if (d != DCC_D_NONE)
			o[d - 2'h1] = r[d - 2'h1] - RW'(1);
		return o;
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.flush = 1'b0;
		s_nxt.exc = 1'b0;
		s_nxt.ret_cnt = 2'h0;
		s_nxt.disp = '0;
		stop = 1'b0;
		ok = 1'b0;
		idx = '0;
		fn = 3'h0;
		op = '0;
		age = '0;
		age_b = '0;
		ng = 2'h0;
		nv = 2'h0;
		nf = 2'h0;
		nd = 3'h0;
		for (int k = 0; k < `DCC_RET_W; k++) begin
			idx = s_r.head + TW'(k);
			if (!stop && s_r.rq_val[idx] && s_r.rq_done[idx]) begin
				if (s_r.rq_exc[idx]) begin
					s_nxt.exc = 1'b1;
					s_nxt.exc_tag = idx;
					stop = 1'b1;
				end else begin
					s_nxt.rq_val[idx] = 1'b0;
					s_nxt.ren = ren_free(s_nxt.ren, s_r.rq_dst[idx]);
					s_nxt.ret_cnt = s_nxt.ret_cnt + 2'h1;
					s_nxt.head = idx + TW'(1);
					s_nxt.rq_cnt = s_nxt.rq_cnt - (TW+1)'(1);
				end
			end else begin
				stop = 1'b1;
			end
		end
		if (s_nxt.exc) begin
			// The excepting entry and everything younger is dropped.
			for (int i = 0; i < RQ_DEPTH; i++) begin
				if (s_nxt.rq_val[i])
					s_nxt.ren = ren_free(s_nxt.ren, s_r.rq_dst[i]);
			end
			s_nxt.rq_val = '0;
			s_nxt.rq_cnt = '0;
			s_nxt.tail = s_nxt.head;
			s_nxt.br_cnt = 2'h0;
			s_nxt.fq_cnt = 5'h0;
			s_nxt.flush = 1'b1;
		end else if (br_res.vld && s_r.rq_val[br_res.tag] &&
			s_r.rq_br[br_res.tag]) begin
			s_nxt.rq_br[br_res.tag] = 1'b0;
			s_nxt.br_cnt = s_nxt.br_cnt - 2'h1;
			if (br_res.miss) begin
				age_b = br_res.tag - s_nxt.head;
				for (int i = 0; i < RQ_DEPTH; i++) begin
					age = TW'(i) - s_nxt.head;
					if (s_nxt.rq_val[i] && age > age_b) begin
						s_nxt.rq_val[i] = 1'b0;
						s_nxt.ren = ren_free(s_nxt.ren, s_r.rq_dst[i]);
						s_nxt.rq_cnt = s_nxt.rq_cnt - (TW+1)'(1);
						if (s_r.rq_br[i])
							s_nxt.br_cnt = s_nxt.br_cnt - 2'h1;
					end
				end
				s_nxt.tail = br_res.tag + TW'(1);
				s_nxt.fq_cnt = 5'h0;
				s_nxt.flush = 1'b1;
			end
		end
		stop = s_nxt.flush;
		for (int k = 0; k < `DCC_DISP_W; k++) begin
			op = s_r.fq[k];
			ok = !stop && (5'(k) < s_r.fq_cnt) &&
				(s_nxt.rq_cnt < (TW+1)'(RQ_DEPTH));
			case (op.q)
				DCC_Q_GEN: ok = ok && ng < gen_room && ng < 2'(`DCC_GEN_MAX);
				DCC_Q_VEC: ok = ok && nv < vec_room && nv < 2'(`DCC_VEC_MAX);
				DCC_Q_FLT: ok = ok && nf < {1'b0, flt_room} &&
					nf < 2'(`DCC_FLT_MAX);
				default: ok = ok;
			endcase
			if (op.d != DCC_D_NONE)
				ok = ok && (s_nxt.ren[op.d - 2'h1] < RW'(REN_DEPTH));
			if (op.br)
				ok = ok && (s_nxt.br_cnt < 2'(BR_MAX));
			if (ok) begin
				s_nxt.disp[k] = '{vld: 1'b1, op: op, tag: s_nxt.tail};
				s_nxt.rq_val[s_nxt.tail] = 1'b1;
				s_nxt.rq_done[s_nxt.tail] = 1'b0;
				s_nxt.rq_exc[s_nxt.tail] = 1'b0;
				s_nxt.rq_br[s_nxt.tail] = op.br;
				s_nxt.rq_dst[s_nxt.tail] = op.d;
				s_nxt.tail = s_nxt.tail + TW'(1);
				s_nxt.rq_cnt = s_nxt.rq_cnt + (TW+1)'(1);
				if (op.d != DCC_D_NONE)
					s_nxt.ren[op.d - 2'h1] = s_nxt.ren[op.d - 2'h1] + RW'(1);
				if (op.br)
					s_nxt.br_cnt = s_nxt.br_cnt + 2'h1;
				ng = ng + ((op.q == DCC_Q_GEN) ? 2'h1 : 2'h0);
				nv = nv + ((op.q == DCC_Q_VEC) ? 2'h1 : 2'h0);
				nf = nf + ((op.q == DCC_Q_FLT) ? 2'h1 : 2'h0);
				nd = nd + 3'h1;
			end else begin
				stop = 1'b1;
			end
		end
		if (!s_nxt.flush) begin
			for (int i = 0; i < FQ_DEPTH; i++)
				s_nxt.fq[i] = (i + int'(nd) < FQ_DEPTH) ? s_r.fq[i + int'(nd)] : '0;
			s_nxt.fq_cnt = s_r.fq_cnt - 5'(nd);
			fn = (fetch_n > 3'h4) ? 3'h4 : fetch_n;
			if (s_r.fetch_rdy) begin
				for (int j = 0; j < `DCC_FETCH_W; j++) begin
					if (3'(j) < fn && int'(s_nxt.fq_cnt) + j < FQ_DEPTH)
						s_nxt.fq[int'(s_nxt.fq_cnt) + j] = fetch_ops[j];
				end
				s_nxt.fq_cnt = s_nxt.fq_cnt + 5'(fn);
			end
		end else begin
			fn = 3'h0;
		end
		// Room for a whole fetch group is kept, so no partial group is lost.
		s_nxt.fetch_rdy = s_nxt.fq_cnt <= 5'(FQ_DEPTH - `DCC_FETCH_W);
		s_nxt.rq_done = s_nxt.rq_done | (fin_mask & s_nxt.rq_val);
		s_nxt.rq_exc = s_nxt.rq_exc | (fin_mask & fin_exc & s_nxt.rq_val);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.fetch_rdy <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fetch_rdy = s_r.fetch_rdy;
	assign disp = s_r.disp;
	assign ret_cnt = s_r.ret_cnt;
	assign flush = s_r.flush;
	assign exc = s_r.exc;
	assign exc_tag = s_r.exc_tag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence miss_seen;
		br_res.vld && br_res.miss && s_r.rq_val[br_res.tag] &&
		s_r.rq_br[br_res.tag] && !s_nxt.exc;
	endsequence
	sequence flushed;
		flush && s_r.fq_cnt == 5'h0 && s_r.disp == '0;
	endsequence

	fq_depth_a: assert property (s_r.fq_cnt <= 5'(FQ_DEPTH))
		else $error("fetch queue overfilled");
	fetch_gate_a: assert property (!fetch_rdy |=> s_r.fq_cnt <= $past(s_r.fq_cnt))
		else $error("fetch accepted while refused");
	disp_order_a: assert property (disp[2].vld |-> disp[1].vld && disp[0].vld)
		else $error("younger slot dispatched past older");
	flt_limit_a: assert property ((disp[0].vld && disp[0].op.q == DCC_Q_FLT) |->
		!(disp[1].vld && disp[1].op.q == DCC_Q_FLT))
		else $error("two float dispatches in a cycle");
	inflight_a: assert property (s_r.rq_cnt <= (TW+1)'(RQ_DEPTH) &&
		s_r.rq_cnt == (TW+1)'($countones(s_r.rq_val)))
		else $error("retire queue count wrong");
	branch_cap_a: assert property (s_r.br_cnt <= 2'(BR_MAX))
		else $error("too many unresolved branches");
	rename_cap_a: assert property (s_r.ren[0] <= RW'(REN_DEPTH) &&
		s_r.ren[1] <= RW'(REN_DEPTH) && s_r.ren[2] <= RW'(REN_DEPTH))
		else $error("rename buffers overcommitted");
	retire_done_a: assert property (ret_cnt != 2'h0 |->
		$past(s_r.rq_done[s_r.head]))
		else $error("unfinished instruction retired");
	miss_flush_a: assert property (miss_seen |=> flushed)
		else $error("mispredict did not flush");
	exc_precise_a: assert property (exc |-> s_r.rq_cnt == '0 && flush &&
		s_r.head == exc_tag)
		else $error("exception not precise");
endmodule // dcc_core

// ===== rtl/dcc_map.svh
// Sizing and limit constants of the dispatch and completion control.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_FETCH_W 4
`define DCC_FQ_DEPTH 12
`define DCC_DISP_W 3
`define DCC_RET_W 3
`define DCC_RQ_DEPTH 16
`define DCC_TAG_W 4
`define DCC_REN_DEPTH 16
`define DCC_BR_MAX 3
`define DCC_GEN_MAX 3
`define DCC_VEC_MAX 2
`define DCC_FLT_MAX 1
`endif

// ===== rtl/dcc_pkg.sv
// Types shared by the dispatch and completion control.
`include "dcc_map.svh"
package dcc_pkg;
	typedef enum logic [1:0] {
		DCC_Q_GEN = 2'h0,
		DCC_Q_VEC = 2'h1,
		DCC_Q_FLT = 2'h2,
		DCC_Q_NONE = 2'h3
	} dcc_queue_t;
	typedef enum logic [1:0] {
		DCC_D_NONE = 2'h0,
		DCC_D_INT = 2'h1,
		DCC_D_FLT = 2'h2,
		DCC_D_VEC = 2'h3
	} dcc_dest_t;
	typedef struct packed {
		dcc_queue_t q;
		dcc_dest_t d;
		logic br;
	} dcc_op_t;
	typedef struct packed {
		logic vld;
		dcc_op_t op;
		logic [`DCC_TAG_W-1:0] tag;
	} dcc_disp_t;
	typedef struct packed {
		logic vld;
		logic [`DCC_TAG_W-1:0] tag;
		logic miss;
	} dcc_res_t;
endpackage

// ===== verif/dcc_exec_model.sv
// Model of the execution units: queue room, finish marks, branch results.
`timescale 1ns/1ps
module dcc_exec_model import dcc_pkg::*; (
	input wire logic clk,
	input wire logic stall,
	input wire logic miss_on,
	input wire logic exc_on,
	input wire dcc_disp_t [2:0] disp,
	input wire logic flush,
	output logic [1:0] gen_room,
	output logic [1:0] vec_room,
	output logic flt_room,
	output logic [15:0] fin_mask,
	output logic [15:0] fin_exc,
	output dcc_res_t br_res,
	output logic [3:0] exc_tag_exp
);
	dcc_disp_t pend[$];
	logic hold = 1'b0;
	logic xhold = 1'b0;
	initial {gen_room, vec_room, flt_room, fin_mask, fin_exc, br_res,
		exc_tag_exp} = '0;
	always @(posedge clk) begin
		// A mispredicted branch stays behind to finish; younger work is gone.
		if (flush === 1'b1) begin
			if (hold && pend.size() > 0)
				pend = pend[0:0];
			else
				pend.delete();
			hold = 1'b0;
			xhold = 1'b0;
		end
		for (int i = 0; i < 3; i++)
			if (disp[i].vld === 1'b1)
				pend.push_back(disp[i]);
	end
	// Branches are resolved before they finish, so none retires unresolved.
	always @(negedge clk) begin
		gen_room <= stall ? 2'h0 : 2'($urandom_range(3));
		vec_room <= stall ? 2'h0 : 2'($urandom_range(2));
		flt_room <= stall ? 1'b0 : 1'($urandom_range(1));
		fin_mask <= 16'h0000;
		fin_exc <= 16'h0000;
		br_res <= '0;
		if (!stall && !hold && !xhold && pend.size() > 0 &&
			pend[0].op.br) begin
			br_res <= {1'b1, pend[0].tag, miss_on};
			pend[0].op.br = 1'b0;
			hold = miss_on;
		end else
			for (int i = 0; i < 3; i++)
				if (!stall && !hold && !xhold && pend.size() > 0 &&
					!pend[0].op.br) begin
					fin_mask[pend[0].tag] <= 1'b1;
					fin_exc[pend[0].tag] <= exc_on;
					// Only one fault is raised, so the expected tag stays put.
					if (exc_on) begin
						exc_tag_exp <= pend[0].tag;
						xhold = 1'b1;
					end
					void'(pend.pop_front());
				end
	end
endmodule // dcc_exec_model

// ===== verif/tb.sv
// Self-checking bench of the dispatch and completion control.
`timescale 1ns/1ps
module tb import dcc_pkg::*; ;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic stall = 1'b1;
	logic miss_on = 1'b0;
	logic exc_on = 1'b0;
	logic sync = 1'b1;
	logic [2:0] fetch_n = 3'h0;
	dcc_op_t [3:0] fetch_ops = '0;
	logic fetch_rdy, flt_room, flush, exc;
	logic [1:0] gen_room, vec_room, ret_cnt;
	logic [15:0] fin_mask, fin_exc;
	logic [3:0] exc_tag, exc_tag_exp;
	logic [3:0] tag_e = 4'h0;
	logic [3:0] ftag = 4'h0;
	logic [4:0] pr = 5'h00;
	dcc_disp_t [2:0] disp;
	dcc_res_t br_res;
	dcc_op_t exp_q[$];
	int mismatches = 0, compares = 0, acc = 0, infl = 0, nbr = 0;
	int npush = 12, ndisp = 0, nret = 0, nflush = 0, nexc = 0, n0, n;
	int c[4];
	always #2.5 clk = ~clk;
	dcc_core DUT (.clk(clk), .rst_n(rst_n), .fetch_n(fetch_n),
		.fetch_ops(fetch_ops), .fetch_rdy(fetch_rdy), .gen_room(gen_room),
		.vec_room(vec_room), .flt_room(flt_room), .disp(disp),
		.fin_mask(fin_mask), .fin_exc(fin_exc), .br_res(br_res),
		.ret_cnt(ret_cnt), .flush(flush), .exc(exc), .exc_tag(exc_tag));
	dcc_exec_model model (.clk(clk), .stall(stall), .miss_on(miss_on),
		.exc_on(exc_on), .disp(disp), .flush(flush), .gen_room(gen_room),
		.vec_room(vec_room), .flt_room(flt_room), .fin_mask(fin_mask),
		.fin_exc(fin_exc), .br_res(br_res), .exc_tag_exp(exc_tag_exp));
	task automatic check(input string s, input logic [15:0] e, x);
		compares++;
		if (x !== e) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", s, e, x);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wait_for(ref int cnt, input int t);
		int w;
		for (w = 0; w < 500 && cnt < t; w++)
			@(negedge clk);
		if (cnt < t) begin
			mismatches++;
			final_report();
		end
	endtask
	task automatic send(input int k, input logic b);
		int w;
		fetch_n = 3'(k);
		for (int i = 0; i < 4; i++)
			fetch_ops[i] = 5'($urandom) | 5'(i == 0 && b);
		for (w = 0; w < 300 && fetch_rdy !== 1'b1; w++)
			@(negedge clk);
		if (fetch_rdy !== 1'b1) begin
			mismatches++;
			final_report();
		end
		for (int i = 0; i < k; i++)
			exp_q.push_back(fetch_ops[i]);
		npush += k;
		@(negedge clk);
	endtask
	always @(posedge clk) if (rst_n) begin
		c = '{0, 0, 0, 0};
		n = 0;
		for (int i = 0; i < 3; i++) if (disp[i].vld === 1'b1) begin
			n++;
			c[disp[i].op.q]++;
			nbr += disp[i].op.br;
			if (i > 0) check("gap", 1, disp[i - 1].vld);
			check("op", 16'(exp_q.pop_front()), 16'(disp[i].op));
			check("tag", tag_e, disp[i].tag);
			tag_e++;
		end
		if (br_res.vld === 1'b1) nbr--;
		if (br_res.vld === 1'b1 && br_res.miss === 1'b1)
			ftag = br_res.tag + 4'h1;
		infl += n - ret_cnt;
		ndisp += n;
		nret += ret_cnt;
		// Discarded work is never counted back, so this holds until a flush.
		if (sync) check("flight", 1, infl >= 0 && infl <= 16);
		check("branch", 1, nbr <= 3);
		check("room", 1, c[0] <= pr[4:3] && c[1] <= pr[2:1]);
		check("froom", 1, c[2] <= pr[0]);
		if (flush === 1'b1) begin
			nflush++;
			sync = 1'b0;
			check("fl_disp", 0, n);
			// Older branches were resolved in order and younger ones are gone.
			nbr = 0;
			exp_q.delete();
			tag_e = (exc === 1'b1) ? exc_tag_exp : ftag;
		end
		if (exc === 1'b1) begin
			nexc++;
			check("exc_tag", exc_tag_exp, exc_tag);
			check("exc_fl", 1, flush);
		end
		if (fetch_rdy === 1'b1) acc += fetch_n;
		pr = {gen_room, vec_room, flt_room};
	end
	initial begin
		void'($urandom(70206));
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		fetch_n = 3'h4;
		repeat (6) @(negedge clk);
		check("fill", 12, acc);
		fetch_n = 3'h0;
		repeat (12) exp_q.push_back('0);
		stall = 1'b0;
		repeat (40) send(1 + $urandom_range(3), 1'b0);
		fetch_n = 3'h0;
		wait_for(nret, npush);
		check("retired", npush, nret);
		check("idle", 0, infl);
		miss_on = 1'b1;
		send(4, 1'b1);
		fetch_n = 3'h0;
		wait_for(nflush, 1);
		miss_on = 1'b0;
		n0 = ndisp + 8;
		repeat (2) send(4, 1'b0);
		fetch_n = 3'h0;
		wait_for(ndisp, n0);
		exc_on = 1'b1;
		send(4, 1'b0);
		fetch_n = 3'h0;
		wait_for(nexc, 1);
		exc_on = 1'b0;
		rst_n = 1'b0;
		@(negedge clk);
		check("rst_rdy", 1, fetch_rdy);
		check("rst_disp", 1, disp === '0);
		check("rst_out", 0, {ret_cnt, flush, exc, exc_tag});
		rst_n = 1'b1;
		tag_e = 4'h0;
		exp_q.delete();
		n0 = ndisp + 3;
		send(3, 1'b0);
		fetch_n = 3'h0;
		wait_for(ndisp, n0);
		final_report();
	end
endmodule // tb
